// ---- src/txbsf_pkg.sv ----
package txbsf_pkg;

  // Command word A fields.
  localparam int CMDA_FIRST_BIT = 13;
  localparam int CMDA_LAST_BIT = 12;
  localparam int CMDA_SIZE_MSB = 10;
  localparam int CMDA_OFF_LSB = 16;
  localparam int CMDA_ALIGN_LSB = 24;
  // Command word B fields.
  localparam int CMDB_TAG_LSB = 16;
  localparam int CMDB_LEN_MSB = 10;

  // End alignment codes, named by the alignment in bytes.
  localparam logic [1:0] ALIGN_4 = 2'h0;
  localparam logic [1:0] ALIGN_16 = 2'h1;
  localparam logic [1:0] ALIGN_32 = 2'h2;

  // Status word layout.
  localparam int ST_ES_BIT = 15;
  localparam int ST_LOC_BIT = 11;
  localparam int ST_NOC_BIT = 10;
  localparam int ST_LATE_BIT = 9;
  localparam int ST_EXC_BIT = 8;
  localparam int ST_COL_LSB = 3;
  localparam int ST_EDEF_BIT = 2;
  localparam int ST_RSV1_BIT = 1;
  localparam int ST_DEF_BIT = 0;

  // Status FIFO geometry.
  localparam int ST_DEPTH = 16;
  localparam int ST_AW = 4;

  // Register offsets and bits.
  localparam logic [3:0] REG_CFG = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_INFO = 4'h8;
  localparam int CFG_SAO_BIT = 0;
  localparam int CFG_DEFCHK_BIT = 1;
  localparam int INFO_ERR_BIT = 16;
  localparam logic [1:0] CFG_RESET = 2'h0;

  // Parser states.
  typedef enum logic [2:0] {
    TXBSF_CMD_A = 3'b000,
    TXBSF_CMD_B = 3'b001,
    TXBSF_SKIP = 3'b010,
    TXBSF_DATA = 3'b011,
    TXBSF_PAD = 3'b100
  } txbsf_state_t;

  // Per-packet completion report from the MAC layer.
  typedef struct packed {
    logic carrier_lost;
    logic no_carrier;
    logic late_collision;
    logic excess_collisions;
    logic [3:0] collision_count;
    logic excess_deferral;
    logic deferred;
  } txbsf_report_t;

endpackage

// ---- src/txbsf_top.sv ----
`timescale 1ns/1ps
`default_nettype none

// What this block does
// RQ1: Host keeps middle buffers at least four bytes.
// RQ2: Any alignment, any first or last length.
// RQ3: Host keeps packet under 2036 MAC bytes.
// RQ4: Commands and whole padding words never reach MAC.
// RQ5: Host may reject packets over 86 buffers.
// RQ6: One status word per transmitted packet.
// RQ7: Full status FIFO holds transmission off.
// RQ8: Discard mode keeps running, count shows zero.
// RQ9: Discard mode overrun raises no error flag.
// RQ10: Host resynchronises status after an overrun.
// RQ11: Status top half carries the packet tag.
// RQ12: Error summary ORs bits 11,10,9,8,2,1.
// RQ13: Bits 11 and 10 report carrier problems.
// RQ14: Bit 9 reports a late collision.
// RQ15: Bit 8 reports sixteen collisions abort.
// RQ16: Bits 6:3 hold the collision count.
// RQ17: Bit 2 excess deferral only when checking.
// RQ18: Bit 0 reports deferral.
// RQ19: Command A taken for every buffer.
// RQ20: Command B taken only for first segment.
// RQ21: Whole offset words dropped, partial word passed.
// RQ22: Whole pad words dropped, payload all passed.
// RQ23: Summed buffer sizes must match packet length.
// RQ24: Command B must match across packet buffers.
// RQ25: Status pushed only once the packet ends.
module txbsf_top (
  input wire logic clock_in, // System clock, 10 MHz.
  input wire logic rstn_in, // Asynchronous reset, active low.
  input wire logic host_valid_in, // Host offers a data-port word.
  input wire logic [31:0] host_data_in, // Data-port word.
  output logic host_ready_out, // Word is taken when valid and ready.
  output logic mac_valid_out, // Word for the MAC transmit FIFO.
  output logic [31:0] mac_data_out, // Stripped payload word.
  output logic mac_last_out, // Last word of the packet.
  input wire logic mac_ready_in, // MAC FIFO accepts the word.
  input wire logic done_valid_in, // MAC finished or abandoned a packet.
  input wire txbsf_pkg::txbsf_report_t done_in, // Outcome of that packet.
  output logic mac_hold_out, // Suspend transmission.
  input wire logic [3:0] addr_in, // Register address.
  input wire logic [31:0] wdata_in, // Register write data.
  input wire logic wr_in, // Register write strobe.
  input wire logic rd_in, // Register read strobe.
  output logic [31:0] rdata_out, // Read data, one cycle after strobe.
  output logic tx_error_flag_out // Sticky transmitter error.
);

  txbsf_pkg::txbsf_state_t state;
  logic [1:0] cfg;
  logic [31:0] cmd_a;
  logic [31:0] cmd_b;
  logic [10:0] size_sum;
  logic [9:0] wcnt;
  logic [2:0] skip_words;
  logic [9:0] data_words;
  logic [9:0] pad_words;
  logic [31:0] fifo_mem [txbsf_pkg::ST_DEPTH];
  logic [txbsf_pkg::ST_AW-1:0] wr_ptr;
  logic [txbsf_pkg::ST_AW-1:0] rd_ptr;
  logic [txbsf_pkg::ST_AW:0] used;
  logic overrun;
  logic [15:0] done_tag;
  logic mid_packet;

  logic take;
  logic pass_word;
  logic last_data;
  logic buf_err;
  logic st_full;
  logic st_empty;
  logic st_push;
  logic st_pop;
  logic st_ovf_err;
  logic [31:0] st_word;
  logic next_out_valid;
  logic [4:0] a_off;
  logic [10:0] a_size;
  logic [12:0] a_span;
  logic [9:0] a_words;
  logic [9:0] a_data;
  logic [9:0] a_padded;

  // Rounds a word count up to the end alignment of the buffer.
  function automatic logic [9:0] align_up(input logic [9:0] w,
                                          input logic [1:0] code);
    logic [9:0] r;
    r = w;
    if (code == txbsf_pkg::ALIGN_16) begin
      r = (w + 10'h3) & 10'h3fc;
    end else if (code == txbsf_pkg::ALIGN_32) begin
      r = (w + 10'h7) & 10'h3f8;
    end
    return r;
  endfunction

  // Geometry of the buffer described by an incoming command A.
  always_comb begin
    a_off = host_data_in[txbsf_pkg::CMDA_OFF_LSB +: 5];
    a_size = host_data_in[txbsf_pkg::CMDA_SIZE_MSB:0];
    a_span = {8'h00, a_off} + {2'h0, a_size};
    a_words = a_span[11:2] + {9'h000, |a_span[1:0]};
    a_data = a_words - {7'h00, a_off[4:2]};
    a_padded = align_up(a_words,
                        host_data_in[txbsf_pkg::CMDA_ALIGN_LSB +: 2]);
  end

  // Handshake, stripping decisions and buffer checks.
  assign take = host_valid_in & host_ready_out;
  assign pass_word = take & (state == txbsf_pkg::TXBSF_DATA); // RQ4
  assign last_data = (wcnt + 10'h001 == data_words);
  assign st_full = (used == txbsf_pkg::ST_DEPTH[txbsf_pkg::ST_AW:0]);
  assign st_empty = (used == '0);

  // A packet ending makes the length check; a repeated B must match.
  always_comb begin
    buf_err = 1'b0;
    if (take && state == txbsf_pkg::TXBSF_CMD_B && mid_packet &&
        host_data_in != cmd_b) begin
      buf_err = 1'b1; // RQ24
    end
    if (take && state == txbsf_pkg::TXBSF_CMD_A && mid_packet &&
        host_data_in[txbsf_pkg::CMDA_FIRST_BIT] &&
        cmd_b != host_data_in) begin
      buf_err = buf_err;
    end
    if (pass_word && last_data && cmd_a[txbsf_pkg::CMDA_LAST_BIT] &&
        size_sum != cmd_b[txbsf_pkg::CMDB_LEN_MSB:0]) begin
      buf_err = 1'b1; // RQ23
    end
  end

  // Parser state machine over the command and data words.
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state <= txbsf_pkg::TXBSF_CMD_A;
      wcnt <= '0;
    end else if (take) begin
      wcnt <= wcnt + 10'h001;
      case (state)
        txbsf_pkg::TXBSF_CMD_A: begin
          wcnt <= '0;
          if (host_data_in[txbsf_pkg::CMDA_FIRST_BIT]) begin
            state <= txbsf_pkg::TXBSF_CMD_B; // RQ20
          end else if (a_off[4:2] != 3'h0) begin
            state <= txbsf_pkg::TXBSF_SKIP;
          end else if (a_data != 10'h000) begin
            state <= txbsf_pkg::TXBSF_DATA;
          end else if (a_padded != a_words) begin
            state <= txbsf_pkg::TXBSF_PAD;
          end
        end
        txbsf_pkg::TXBSF_CMD_B: begin
          wcnt <= '0;
          if (skip_words != 3'h0) begin
            state <= txbsf_pkg::TXBSF_SKIP;
          end else if (data_words != 10'h000) begin
            state <= txbsf_pkg::TXBSF_DATA;
          end else if (pad_words != 10'h000) begin
            state <= txbsf_pkg::TXBSF_PAD;
          end else begin
            state <= txbsf_pkg::TXBSF_CMD_A;
          end
        end
        txbsf_pkg::TXBSF_SKIP: begin
          if (wcnt[2:0] + 3'h1 == skip_words) begin
            wcnt <= '0; // RQ21
            state <= (data_words != 10'h000) ? txbsf_pkg::TXBSF_DATA :
                     txbsf_pkg::TXBSF_PAD;
          end
        end
        txbsf_pkg::TXBSF_DATA: begin
          if (last_data) begin
            wcnt <= '0; // RQ2
            state <= (pad_words != 10'h000) ? txbsf_pkg::TXBSF_PAD :
                     txbsf_pkg::TXBSF_CMD_A;
          end
        end
        txbsf_pkg::TXBSF_PAD: begin
          if (wcnt + 10'h001 == pad_words) begin
            state <= txbsf_pkg::TXBSF_CMD_A; // RQ22
          end
        end
        default: begin
          state <= txbsf_pkg::TXBSF_CMD_A;
        end
      endcase
    end
  end

  // Command capture, buffer geometry and running length per packet.
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cmd_a <= '0;
      cmd_b <= '0;
      size_sum <= '0;
      skip_words <= '0;
      data_words <= '0;
      pad_words <= '0;
      mid_packet <= 1'b0;
    end else if (take) begin
      if (state == txbsf_pkg::TXBSF_CMD_A) begin
        cmd_a <= host_data_in; // RQ19
        skip_words <= a_off[4:2];
        data_words <= a_data;
        pad_words <= a_padded - a_words;
        if (host_data_in[txbsf_pkg::CMDA_FIRST_BIT]) begin
          size_sum <= a_size;
        end else begin
          size_sum <= size_sum + a_size; // RQ23
        end
      end
      if (state == txbsf_pkg::TXBSF_CMD_B) begin
        cmd_b <= host_data_in;
        mid_packet <= 1'b1;
      end
      if (pass_word && last_data && cmd_a[txbsf_pkg::CMDA_LAST_BIT]) begin
        mid_packet <= 1'b0;
      end
    end
  end

  // Output stage toward the MAC; ready is held off while a word waits.
  assign next_out_valid = pass_word | (mac_valid_out & ~mac_ready_in);
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      mac_valid_out <= 1'b0;
      mac_data_out <= '0;
      mac_last_out <= 1'b0;
      host_ready_out <= 1'b0;
    end else begin
      mac_valid_out <= next_out_valid;
      host_ready_out <= ~next_out_valid;
      if (pass_word) begin
        mac_data_out <= host_data_in;
        mac_last_out <= last_data & cmd_a[txbsf_pkg::CMDA_LAST_BIT];
      end
    end
  end

  // Tag of the packet in flight to the MAC, used for its status.
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      done_tag <= '0;
    end else if (take && state == txbsf_pkg::TXBSF_CMD_B && !mid_packet) begin
      done_tag <= host_data_in[txbsf_pkg::CMDB_TAG_LSB +: 16];
    end
  end

  // Assemble the status word from the MAC report.
  always_comb begin
    st_word = '0;
    st_word[31:16] = done_tag; // RQ11
    st_word[txbsf_pkg::ST_LOC_BIT] = done_in.carrier_lost; // RQ13
    st_word[txbsf_pkg::ST_NOC_BIT] = done_in.no_carrier; // RQ13
    st_word[txbsf_pkg::ST_LATE_BIT] = done_in.late_collision; // RQ14
    st_word[txbsf_pkg::ST_EXC_BIT] = done_in.excess_collisions; // RQ15
    st_word[txbsf_pkg::ST_COL_LSB +: 4] = done_in.collision_count; // RQ16
    st_word[txbsf_pkg::ST_EDEF_BIT] = done_in.excess_deferral &
                                      cfg[txbsf_pkg::CFG_DEFCHK_BIT]; // RQ17
    st_word[txbsf_pkg::ST_DEF_BIT] = done_in.deferred; // RQ18
    st_word[txbsf_pkg::ST_ES_BIT] = st_word[11] | st_word[10] |
                                    st_word[9] | st_word[8] |
                                    st_word[2] | st_word[1]; // RQ12
  end

  // Status FIFO control; pushes only on a finished packet.
  assign st_pop = rd_in & (addr_in == txbsf_pkg::REG_STATUS) & ~st_empty;
  assign st_push = done_valid_in & ~st_full & ~overrun; // RQ25
  assign st_ovf_err = done_valid_in & (st_full | overrun) &
                      ~cfg[txbsf_pkg::CFG_SAO_BIT]; // RQ9

  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      used <= '0;
    end else begin
      if (st_push) begin
        wr_ptr <= wr_ptr + 1'b1; // RQ6
      end
      if (st_pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      used <= used + {4'h0, st_push} - {4'h0, st_pop};
    end
  end

  // Flip-flop storage of the status words.
  always_ff @(posedge clock_in) begin
    if (st_push) begin
      fifo_mem[wr_ptr] <= st_word;
    end
  end

  // Overrun in discard mode blocks pushes until the host reads status.
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      overrun <= 1'b0;
    end else if (done_valid_in && st_full && cfg[txbsf_pkg::CFG_SAO_BIT]) begin
      overrun <= 1'b1; // RQ8
    end else if (st_pop) begin
      overrun <= 1'b0;
    end
  end

  // Hold transmission while the FIFO is full, unless discarding.
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      mac_hold_out <= 1'b0;
    end else begin
      mac_hold_out <= ((used + {4'h0, st_push} - {4'h0, st_pop}) ==
                       txbsf_pkg::ST_DEPTH[txbsf_pkg::ST_AW:0]) &
                      ~cfg[txbsf_pkg::CFG_SAO_BIT]; // RQ7
    end
  end

  // Sticky error flag; a new error wins over a write-one clear.
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      tx_error_flag_out <= 1'b0;
    end else if (buf_err || st_ovf_err) begin
      tx_error_flag_out <= 1'b1;
    end else if (wr_in && addr_in == txbsf_pkg::REG_INFO &&
                 wdata_in[txbsf_pkg::INFO_ERR_BIT]) begin
      tx_error_flag_out <= 1'b0;
    end
  end

  // Configuration register.
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cfg <= txbsf_pkg::CFG_RESET;
    end else if (wr_in && addr_in == txbsf_pkg::REG_CFG) begin
      cfg <= wdata_in[1:0];
    end
  end

  // Read data, valid in the cycle after the strobe.
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rdata_out <= '0;
    end else if (rd_in) begin
      case (addr_in)
        txbsf_pkg::REG_CFG: rdata_out <= {30'h0, cfg};
        txbsf_pkg::REG_STATUS: rdata_out <= st_empty ? 32'h0 :
                                            fifo_mem[rd_ptr];
        txbsf_pkg::REG_INFO: begin
          rdata_out <= {15'h0, tx_error_flag_out, 11'h0,
                        overrun ? 5'h00 : used}; // RQ8
        end
        default: rdata_out <= 32'h0;
      endcase
    end else begin
      rdata_out <= 32'h0;
    end
  end

  a_hold_on_full: assert property (@(posedge clock_in) disable iff (!rstn_in)
    st_full && !st_pop && !cfg[0] |=> mac_hold_out) // RQ7
    else $error("full status FIFO did not hold transmission");
  a_summary_or: assert property (@(posedge clock_in) disable iff (!rstn_in)
    st_push |-> st_word[15] == (|{st_word[11:8], st_word[2:1]})) // RQ12
    else $error("error summary bit wrong");
  a_tag_copy: assert property (@(posedge clock_in) disable iff (!rstn_in)
    st_push |=> fifo_mem[$past(wr_ptr)][31:16] == $past(done_tag)) // RQ11
    else $error("status tag does not match command tag");
  a_ovr_count_zero: assert property (@(posedge clock_in)
    disable iff (!rstn_in)
    overrun && rd_in && addr_in == 4'h8 && !st_pop |=> rdata_out[4:0] == 0)
    else $error("used count not zero during overrun"); // RQ8
  a_sao_no_error: assert property (@(posedge clock_in) disable iff (!rstn_in)
    cfg[0] && done_valid_in && st_full && !buf_err && !tx_error_flag_out
    |=> !tx_error_flag_out) // RQ9
    else $error("discard-mode overrun raised the error flag");
  a_skip_dropped: assert property (@(posedge clock_in) disable iff (!rstn_in)
    take && state != txbsf_pkg::TXBSF_DATA && !mac_valid_out
    |=> !mac_valid_out) // RQ4
    else $error("stripped word reached the MAC");
  a_one_push: assert property (@(posedge clock_in) disable iff (!rstn_in)
    done_valid_in && !st_full && !overrun && !st_pop
    |=> used == $past(used) + 1) // RQ6
    else $error("status word not stored for packet");
  a_defer_gate: assert property (@(posedge clock_in) disable iff (!rstn_in)
    !cfg[1] |-> !st_word[2]) // RQ17
    else $error("excess deferral reported with checking off");
  a_len_check: assert property (@(posedge clock_in) disable iff (!rstn_in)
    pass_word && last_data && cmd_a[12] && size_sum != cmd_b[10:0]
    |=> tx_error_flag_out) // RQ23
    else $error("length mismatch did not flag an error");
  a_b_match: assert property (@(posedge clock_in) disable iff (!rstn_in)
    take && state == txbsf_pkg::TXBSF_CMD_B && mid_packet &&
    host_data_in != cmd_b |=> tx_error_flag_out) // RQ24
    else $error("command B mismatch did not flag an error");

endmodule

`default_nettype wire

// ---- verif/txbsf_mac_model.sv ----
`timescale 1ns/1ps
`default_nettype none

// Behavioural MAC side: takes stripped words and reports each packet.
module txbsf_mac_model (
  input wire logic clock_in, // System clock.
  input wire logic rstn_in, // Reset, active low.
  input wire logic mac_valid_in, // Word offered by the block.
  input wire logic [31:0] mac_data_in, // Offered word.
  input wire logic mac_last_in, // Last word of the packet.
  output logic mac_ready_out, // Word accepted at this edge.
  input wire logic stall_in, // Accept only every other cycle.
  input wire logic kick_in, // Report one extra packet.
  input wire txbsf_pkg::txbsf_report_t report_in, // Outcome to report.
  output logic done_valid_out, // One-cycle report pulse.
  output txbsf_pkg::txbsf_report_t done_out, // Report value.
  output logic [7:0] words_out, // Words accepted so far.
  output logic [7:0] lasts_out, // Last flags accepted so far.
  output logic [31:0] first_out // First word of the latest packet.
);
  logic toggle;
  logic fresh;
  logic take;

  // Under stall the ready line toggles, so the block must hold its word.
  assign mac_ready_out = !stall_in || toggle;
  assign take = mac_valid_in && mac_ready_out;

  // Counts traffic; the report follows the last word, never before it.
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      toggle <= 1'b0;
      fresh <= 1'b1;
      words_out <= 8'h00;
      lasts_out <= 8'h00;
      first_out <= 32'h0;
      done_valid_out <= 1'b0;
      done_out <= '0;
    end else begin
      toggle <= !toggle;
      done_valid_out <= kick_in || (take && mac_last_in);
      // Outside the pulse the report lines carry the inverse value.
      done_out <= (kick_in || (take && mac_last_in)) ? report_in : ~report_in;
      if (take) begin
        words_out <= words_out + 8'h01;
        lasts_out <= lasts_out + {7'h0, mac_last_in};
        fresh <= mac_last_in;
        if (fresh) begin
          first_out <= mac_data_in;
        end
      end
    end
  end
endmodule

`default_nettype wire

// ---- verif/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none

module testbench;
  typedef struct packed {
    logic [1:0] cfg;
    logic [4:0] off;
    logic [10:0] size;
    logic [15:0] tag;
    txbsf_pkg::txbsf_report_t rep;
    logic [7:0] words;
    logic [31:0] status;
  } txbsf_row_t;

  logic clock_in, rstn_in, host_valid_in, host_ready_out;
  logic [31:0] host_data_in, mac_data_out, wdata_in, rdata_out, d, first;
  logic mac_valid_out, mac_last_out, mac_ready_in, done_valid_in;
  logic mac_hold_out, wr_in, rd_in, tx_error_flag_out, stall, kick;
  logic [3:0] addr_in;
  logic [7:0] words, lasts, w0, l0;
  txbsf_pkg::txbsf_report_t done_in, report;
  txbsf_row_t rows [7];
  int err_count, n_tests, cycles;

  txbsf_top dut_u (.clock_in(clock_in), .rstn_in(rstn_in),
    .host_valid_in(host_valid_in), .host_data_in(host_data_in),
    .host_ready_out(host_ready_out), .mac_valid_out(mac_valid_out),
    .mac_data_out(mac_data_out), .mac_last_out(mac_last_out),
    .mac_ready_in(mac_ready_in), .done_valid_in(done_valid_in),
    .done_in(done_in), .mac_hold_out(mac_hold_out), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .tx_error_flag_out(tx_error_flag_out));

  txbsf_mac_model mac_u (.clock_in(clock_in), .rstn_in(rstn_in),
    .mac_valid_in(mac_valid_out), .mac_data_in(mac_data_out),
    .mac_last_in(mac_last_out), .mac_ready_out(mac_ready_in),
    .stall_in(stall), .kick_in(kick), .report_in(report),
    .done_valid_out(done_valid_in), .done_out(done_in),
    .words_out(words), .lasts_out(lasts), .first_out(first));

  // Clock of 100 ns period.
  always #50 clock_in = ~clock_in;

  // Cuts a hang short well beyond the expected run length.
  always @(posedge clock_in) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_count++;
      close_out;
    end
  end

  // Prints the counts and the verdict, then ends the run.
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Compares one value and reports a mismatch at once.
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One-cycle register write.
  task automatic reg_wr(input logic [3:0] a, input logic [31:0] v);
    addr_in <= a;
    wdata_in <= v;
    wr_in <= 1'b1;
    @(posedge clock_in);
    wr_in <= 1'b0;
  endtask

  // One-cycle register read; data are taken in the following cycle.
  task automatic reg_rd(input logic [3:0] a, output logic [31:0] v);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clock_in);
    rd_in <= 1'b0;
    @(posedge clock_in);
    v = rdata_out;
  endtask

  // Holds one host word until the block takes it.
  task automatic put(input logic [31:0] w);
    host_valid_in <= 1'b1;
    host_data_in <= w;
    @(posedge clock_in);
    while (host_ready_out !== 1'b1) @(posedge clock_in);
  endtask

  // Sends one buffer: commands, offset words, data; end alignment of 4.
  task automatic send_buf(input logic [4:0] off, input logic [10:0] size,
      input logic fs, input logic ls, input logic [31:0] b);
    logic [31:0] a;
    int n;
    a = 32'h0;
    a[20:16] = off;
    a[13] = fs;
    a[12] = ls;
    a[10:0] = size;
    n = (int'(off[1:0]) + int'(size) + 3) / 4;
    put(a);
    if (fs) put(b);
    for (int i = 0; i < int'(off[4:2]); i++) put(32'hdead_0000 | 32'(i));
    for (int i = 0; i < n; i++) put(32'h1000_0000 | 32'(i));
  endtask

  // Waits a bounded time for the packet report, then lets it land.
  task automatic settle;
    int k;
    k = 0;
    while (done_valid_in !== 1'b1 && k < 60) begin
      @(posedge clock_in);
      k++;
    end
    check({31'h0, done_valid_in}, 32'h1);
    repeat (2) @(posedge clock_in);
  endtask

  // Extra report pulses, one every two cycles.
  task automatic kicks(input int n);
    for (int i = 0; i < n; i++) begin
      kick <= 1'b1;
      @(posedge clock_in);
      kick <= 1'b0;
      @(posedge clock_in);
    end
    repeat (2) @(posedge clock_in);
  endtask

  // Main sequence.
  initial begin
    clock_in = 1'b0;
    rstn_in = 1'b0;
    host_valid_in = 1'b0;
    host_data_in = 32'h0;
    wdata_in = 32'h0;
    addr_in = 4'h0;
    wr_in = 1'b0;
    rd_in = 1'b0;
    stall = 1'b0;
    kick = 1'b0;
    report = '0;
    err_count = 0;
    n_tests = 0;
    cycles = 0;
    rows = '{
      '{2'h0, 5'h00, 11'h004, 16'h0001, 10'h000, 8'h01, 32'h0001_0000},
      '{2'h0, 5'h07, 11'h001, 16'ha5a5, 10'h200, 8'h01, 32'ha5a5_8800},
      '{2'h0, 5'h1e, 11'h00b, 16'h0002, 10'h10c, 8'h04, 32'h0002_8418},
      '{2'h0, 5'h01, 11'h003, 16'h0003, 10'h081, 8'h01, 32'h0003_8201},
      '{2'h0, 5'h02, 11'h006, 16'h0004, 10'h07c, 8'h02, 32'h0004_8178},
      '{2'h0, 5'h00, 11'h005, 16'h0005, 10'h002, 8'h02, 32'h0005_0000},
      '{2'h2, 5'h00, 11'h040, 16'h0006, 10'h002, 8'h10, 32'h0006_8004}};
    repeat (3) @(posedge clock_in);
    check({27'h0, host_ready_out, mac_valid_out, mac_hold_out,
      tx_error_flag_out, |rdata_out}, 32'h0);
    rstn_in <= 1'b1;
    @(posedge clock_in);
    reg_wr(4'hc, 32'hffff_ffff);
    reg_rd(4'hc, d);
    check(d, 32'h0);
    reg_rd(txbsf_pkg::REG_CFG, d);
    check(d, {30'h0, txbsf_pkg::CFG_RESET});
    // Single-buffer packets from the table, one report each.
    for (int r = 0; r < 7; r++) begin
      reg_wr(txbsf_pkg::REG_CFG, {30'h0, rows[r].cfg});
      stall <= r[0];
      report <= rows[r].rep;
      w0 = words;
      send_buf(rows[r].off, rows[r].size, 1'b1, 1'b1,
        {rows[r].tag, 5'h0, rows[r].size});
      host_valid_in <= 1'b0;
      settle;
      check(32'(words - w0), 32'(rows[r].words));
      check(first, 32'h1000_0000);
      reg_rd(txbsf_pkg::REG_INFO, d);
      check(d, 32'h1);
      reg_rd(txbsf_pkg::REG_STATUS, d);
      check(d, rows[r].status);
    end
    // Three buffers of one packet with a short middle buffer, stall off.
    reg_wr(txbsf_pkg::REG_CFG, 32'h0);
    report <= '0;
    w0 = words;
    l0 = lasts;
    send_buf(5'h03, 11'd5, 1'b1, 1'b0, 32'h0077_000b);
    send_buf(5'h00, 11'd4, 1'b0, 1'b0, 32'h0077_000b);
    send_buf(5'h01, 11'd2, 1'b0, 1'b1, 32'h0077_000b);
    host_valid_in <= 1'b0;
    settle;
    check(32'(words - w0), 32'h4);
    check(32'(lasts - l0), 32'h1);
    check({31'h0, tx_error_flag_out}, 32'h0);
    reg_rd(txbsf_pkg::REG_STATUS, d);
    check(d, 32'h0077_0000);
    // Packet length that disagrees with the buffer size.
    send_buf(5'h00, 11'd4, 1'b1, 1'b1, 32'h0088_0005);
    host_valid_in <= 1'b0;
    settle;
    check({31'h0, tx_error_flag_out}, 32'h1);
    reg_rd(txbsf_pkg::REG_INFO, d);
    check(d, 32'h0001_0001);
    reg_wr(txbsf_pkg::REG_INFO, 32'h0001_0000);
    reg_rd(txbsf_pkg::REG_STATUS, d);
    check({31'h0, tx_error_flag_out}, 32'h0);
    // A restarted packet whose command B differs from the first one.
    send_buf(5'h00, 11'd4, 1'b1, 1'b0, 32'h0099_0008);
    send_buf(5'h00, 11'd4, 1'b1, 1'b1, 32'h0099_0004);
    host_valid_in <= 1'b0;
    settle;
    check({31'h0, tx_error_flag_out}, 32'h1);
    reg_wr(txbsf_pkg::REG_INFO, 32'h0001_0000);
    reg_rd(txbsf_pkg::REG_STATUS, d);
    check(d, 32'h0099_0000);
    // Status store filled without discard: hold, then overflow error.
    kicks(16);
    check({31'h0, mac_hold_out}, 32'h1);
    reg_rd(txbsf_pkg::REG_INFO, d);
    check(d, 32'h0000_0010);
    kicks(1);
    check({31'h0, tx_error_flag_out}, 32'h1);
    reg_rd(txbsf_pkg::REG_STATUS, d);
    @(posedge clock_in);
    check({31'h0, mac_hold_out}, 32'h0);
    for (int i = 0; i < 15; i++) reg_rd(txbsf_pkg::REG_STATUS, d);
    reg_wr(txbsf_pkg::REG_INFO, 32'h0001_0000);
    // Discard mode: overrun keeps running, count zero, no error.
    reg_wr(txbsf_pkg::REG_CFG, 32'h1);
    kicks(17);
    check({31'h0, mac_hold_out}, 32'h0);
    reg_rd(txbsf_pkg::REG_INFO, d);
    check(d, 32'h0);
    close_out;
  end
endmodule

`default_nettype wire
